// ---- rtl/spl_prom_loader.sv ----
// Serial configuration memory loader and host access controller
// Contract
// - With the capacity strap low, a 128-byte memory is assumed and seven address bits are sent.
// - With the capacity strap high, a 256/512-byte memory is assumed and nine address bits are sent.
// - After every system reset the default configuration is read from a valid memory.
// - USB transactions are refused until the post-reset load has completed.
// - The loaded station address goes to the upper and lower address registers as default.
// - The host can read, write and erase the memory contents.
// - Stored offsets count 16-bit words, not bytes.
// - A stored length of zero marks the field absent and its hardware default is used.
// - With all string lengths zero, no language identifier is offered.
// - Address 00h holds the signature 0xA5 that marks a valid image.
`timescale 1ns/1ps
`include "spl_defs.svh"

module spl_prom_loader #(
	parameter logic [23:0] WR_TIMEOUT_CYC = 24'(`SPL_WR_TIMEOUT_CYC)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Strap and memory pins
	input wire logic prom_capacity_strap,
	input wire logic promDataIn,
	output logic promCs,
	output logic promSk,
	output logic promDi,
	// Load status
	output logic usbAccept,
	output logic loadDone,
	output logic promValid,
	// Station address
	output logic [15:0] station_addr_upper_reg,
	output logic [31:0] station_addr_lower_reg,
	output logic stationAddrLoad,
	// Descriptors
	output logic devDescPresent,
	output logic [9:0] devDescByteAddr,
	output logic cfgDescPresent,
	output logic [9:0] cfgDescByteAddr,
	output logic [7:0] str0Len,
	output logic [7:0] str1Len,
	output logic [7:0] str2Len,
	output logic langIdEn,
	// Host access
	input wire logic hostReq,
	input wire spl_pkg::spl_host_op_t hostOp,
	input wire logic [8:0] hostAddr,
	input wire logic [7:0] hostWrData,
	output logic hostReady,
	output logic hostDone,
	output logic hostFail,
	output logic [7:0] hostRdData
);

	typedef enum logic [2:0] {
		ST_BOOT, ST_LOAD_WAIT, ST_LOAD_APPLY, ST_READY,
		ST_HOST_EWEN, ST_HOST_WAIT
	} spl_state_t;

	spl_state_t state;
	logic [7:0] img [0:`SPL_IMG_WORDS-1];
	logic [1:0] dataSync;
	logic [1:0] strapSync;
	logic [3:0] bootCnt;
	logic [3:0] loadIdx;
	logic wideAddr;
	logic shStart;
	spl_pkg::spl_op_t shOp;
	logic [8:0] shAddr;
	logic [7:0] shData;
	logic shDone;
	logic shTimedOut;
	logic [7:0] shRd;
	spl_pkg::spl_host_op_t pendOp;
	logic [8:0] pendAddr;
	logic sigBad;
	logic applyNow;

	// Only a full descriptor counts; any other length keeps the default
	function automatic logic descValid(input logic [7:0] len);
		descValid = (len == `SPL_DESC_LEN);
	endfunction

	// Word offset to byte address
	function automatic logic [9:0] wordToByte(input logic [7:0] off);
		wordToByte = {1'b0, off, 1'b0};
	endfunction

	// Pins from outside the clock domain
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dataSync <= 2'h0;
			strapSync <= 2'h0;
		end else if (clkEn) begin
			dataSync <= {dataSync[0], promDataIn};
			strapSync <= {strapSync[0], prom_capacity_strap};
		end
	end

	spl_prom_shift #(
		.WR_TIMEOUT_CYC(WR_TIMEOUT_CYC)
	) u_shift (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.start(shStart),
		.cmdOp(shOp),
		.cmdAddr(shAddr),
		.wrData(shData),
		.wideAddr(wideAddr),
		.done(shDone),
		.timedOut(shTimedOut),
		.rdData(shRd),
		.memDataIn(dataSync[1]),
		.memCs(promCs),
		.memSk(promSk),
		.memDi(promDi)
	);

	assign sigBad = (state == ST_LOAD_WAIT) && shDone &&
		(loadIdx == `SPL_SIG_ADDR) && (shRd != `SPL_SIG_VALUE);
	assign applyNow = (state == ST_LOAD_APPLY);

	// Sequencer for the boot load and host operations
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_BOOT;
			bootCnt <= 4'h0;
			loadIdx <= 4'h0;
			wideAddr <= 1'b0;
			shStart <= 1'b0;
			shOp <= spl_pkg::SPL_OP_READ;
			shAddr <= 9'h000;
			shData <= 8'h00;
			pendOp <= spl_pkg::SPL_HOST_READ;
			pendAddr <= 9'h000;
			hostReady <= 1'b0;
		end else if (clkEn) begin
			shStart <= 1'b0;
			unique case (state)
				ST_BOOT: begin
					// Let the strap synchroniser settle before trusting it
					if (bootCnt == `SPL_BOOT_CYC) begin
						wideAddr <= strapSync[1];
						loadIdx <= `SPL_SIG_ADDR;
						shOp <= spl_pkg::SPL_OP_READ;
						shAddr <= 9'h000;
						shStart <= 1'b1;
						state <= ST_LOAD_WAIT;
					end else begin
						bootCnt <= bootCnt + 4'h1;
					end
				end
				ST_LOAD_WAIT: begin
					if (sigBad) begin
						hostReady <= 1'b1;
						state <= ST_READY;
					end else if (shDone && loadIdx == `SPL_LAST_ADDR) begin
						state <= ST_LOAD_APPLY;
					end else if (shDone) begin
						loadIdx <= loadIdx + 4'h1;
						shAddr <= {5'h00, loadIdx + 4'h1};
						shStart <= 1'b1;
					end
				end
				ST_LOAD_APPLY: begin
					hostReady <= 1'b1;
					state <= ST_READY;
				end
				ST_READY: begin
					if (hostReq) begin
						hostReady <= 1'b0;
						pendOp <= hostOp;
						pendAddr <= hostAddr;
						shData <= hostWrData;
						shStart <= 1'b1;
						if (hostOp == spl_pkg::SPL_HOST_READ) begin
							shOp <= spl_pkg::SPL_OP_READ;
							shAddr <= hostAddr;
							state <= ST_HOST_WAIT;
						end else begin
							// Memory ignores programming until enabled
							shOp <= spl_pkg::SPL_OP_EXT;
							shAddr <= wideAddr ? `SPL_EWEN_ADDR_WIDE :
								`SPL_EWEN_ADDR_NARROW;
							state <= ST_HOST_EWEN;
						end
					end
				end
				ST_HOST_EWEN: begin
					if (shDone) begin
						shOp <= (pendOp == spl_pkg::SPL_HOST_WRITE) ?
							spl_pkg::SPL_OP_WRITE : spl_pkg::SPL_OP_ERASE;
						shAddr <= pendAddr;
						shStart <= 1'b1;
						state <= ST_HOST_WAIT;
					end
				end
				ST_HOST_WAIT: begin
					if (shDone) begin
						hostReady <= 1'b1;
						state <= ST_READY;
					end
				end
			endcase
		end
	end

	// Image capture during the boot load
	always_ff @(posedge sys_clk) begin
		if (clkEn && state == ST_LOAD_WAIT && shDone) begin
			img[loadIdx] <= shRd;
		end
	end

	// Load status; USB is held off until the load resolves
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			usbAccept <= 1'b0;
			loadDone <= 1'b0;
			promValid <= 1'b0;
		end else if (clkEn) begin
			if (sigBad || applyNow) begin
				usbAccept <= 1'b1;
				loadDone <= 1'b1;
				promValid <= applyNow;
			end
		end
	end

	// Station address; left untouched for software when image is bad
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			station_addr_upper_reg <= 16'h0000;
			station_addr_lower_reg <= 32'h00000000;
			stationAddrLoad <= 1'b0;
		end else if (clkEn) begin
			stationAddrLoad <= applyNow;
			if (applyNow) begin
				station_addr_lower_reg <= {img[`SPL_MAC_FIRST+3],
					img[`SPL_MAC_FIRST+2], img[`SPL_MAC_FIRST+1],
					img[`SPL_MAC_FIRST]};
				station_addr_upper_reg <= {img[`SPL_MAC_FIRST+5],
					img[`SPL_MAC_FIRST+4]};
			end
		end
	end

	// Descriptor fields; absent ones clear their present flag, byte addresses load regardless
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			devDescPresent <= 1'b0;
			devDescByteAddr <= `SPL_RST_ADDR;
			cfgDescPresent <= 1'b0;
			cfgDescByteAddr <= `SPL_RST_ADDR;
			str0Len <= `SPL_RST_BYTE;
			str1Len <= `SPL_RST_BYTE;
			str2Len <= `SPL_RST_BYTE;
			langIdEn <= 1'b0;
		end else if (clkEn && applyNow) begin
			devDescPresent <= descValid(img[`SPL_DEV_LEN]);
			devDescByteAddr <= wordToByte(img[`SPL_DEV_OFF]);
			cfgDescPresent <= descValid(img[`SPL_CFG_LEN]);
			cfgDescByteAddr <= wordToByte(img[`SPL_CFG_OFF]);
			str0Len <= img[`SPL_STR0_LEN];
			str1Len <= img[`SPL_STR1_LEN];
			str2Len <= img[`SPL_STR2_LEN];
			langIdEn <= (img[`SPL_STR0_LEN] != `SPL_LEN_ABSENT) ||
				(img[`SPL_STR1_LEN] != `SPL_LEN_ABSENT) ||
				(img[`SPL_STR2_LEN] != `SPL_LEN_ABSENT);
		end
	end

	// Host answer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hostDone <= 1'b0;
			hostFail <= 1'b0;
			hostRdData <= 8'h00;
		end else if (clkEn) begin
			hostDone <= (state == ST_HOST_WAIT) && shDone;
			if (state == ST_HOST_WAIT && shDone) begin
				hostFail <= shTimedOut;
				hostRdData <= shRd;
			end
		end
	end

endmodule

// ---- common/spl_defs.svh ----
// Constants of the serial configuration memory loader
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

// Timing
`define SPL_CLK_NS 4
`define SPL_SK_HALF_NS 500
`define SPL_SK_HALF_CYC (`SPL_SK_HALF_NS / `SPL_CLK_NS)
`define SPL_WR_TIMEOUT_NS 10000000
`define SPL_WR_TIMEOUT_CYC (`SPL_WR_TIMEOUT_NS / `SPL_CLK_NS)
`define SPL_BOOT_CYC 4'h3

// Image layout, byte addresses
`define SPL_SIG_ADDR 4'h0
`define SPL_SIG_VALUE 8'ha5
`define SPL_MAC_FIRST 4'h1
`define SPL_DEV_LEN 4'h7
`define SPL_DEV_OFF 4'h8
`define SPL_CFG_LEN 4'h9
`define SPL_CFG_OFF 4'ha
`define SPL_STR0_LEN 4'hb
`define SPL_STR1_LEN 4'hc
`define SPL_STR2_LEN 4'hd
`define SPL_LAST_ADDR 4'hd
`define SPL_IMG_WORDS 14

// Descriptor lengths
`define SPL_DESC_LEN 8'h12
`define SPL_LEN_ABSENT 8'h00

// Enable-write command address in each addressing mode
`define SPL_EWEN_ADDR_WIDE 9'h180
`define SPL_EWEN_ADDR_NARROW 9'h060

// Reset values
`define SPL_RST_BYTE 8'h00
`define SPL_RST_ADDR 10'h000

`endif

// ---- common/spl_pkg.sv ----
// Types of the serial configuration memory loader
package spl_pkg;

	// Serial opcodes after the start bit
	typedef enum logic [1:0] {
		SPL_OP_EXT = 2'h0,
		SPL_OP_WRITE = 2'h1,
		SPL_OP_READ = 2'h2,
		SPL_OP_ERASE = 2'h3
	} spl_op_t;

	// Host operation codes
	typedef enum logic [1:0] {
		SPL_HOST_READ = 2'h0,
		SPL_HOST_WRITE = 2'h1,
		SPL_HOST_ERASE = 2'h2
	} spl_host_op_t;

endpackage

// ---- rtl/spl_prom_shift.sv ----
// Three-wire serial command engine for the configuration memory
`timescale 1ns/1ps
`include "spl_defs.svh"

module spl_prom_shift #(
	parameter logic [23:0] WR_TIMEOUT_CYC = 24'(`SPL_WR_TIMEOUT_CYC)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Command
	input wire logic start,
	input wire spl_pkg::spl_op_t cmdOp,
	input wire logic [8:0] cmdAddr,
	input wire logic [7:0] wrData,
	input wire logic wideAddr,
	// Answer
	output logic done,
	output logic timedOut,
	output logic [7:0] rdData,
	// Memory pins, data in already synchronised
	input wire logic memDataIn,
	output logic memCs,
	output logic memSk,
	output logic memDi
);

	typedef enum logic [2:0] {SH_IDLE, SH_SHIFT, SH_GAP, SH_POLL, SH_FIN} spl_sh_t;

	spl_sh_t state;
	logic [19:0] outBits;
	logic [4:0] bitsLeft;
	logic [7:0] divCnt;
	logic [23:0] waitCnt;
	spl_pkg::spl_op_t op;
	logic tick;

	assign tick = (divCnt == 8'(`SPL_SK_HALF_CYC - 1));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt <= 8'h00;
		end else if (clkEn) begin
			if (state == SH_IDLE || tick) begin
				divCnt <= 8'h00;
			end else begin
				divCnt <= divCnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SH_IDLE;
			outBits <= 20'h00000;
			bitsLeft <= 5'h00;
			waitCnt <= 24'h000000;
			op <= spl_pkg::SPL_OP_EXT;
			memCs <= 1'b0;
			memSk <= 1'b0;
			memDi <= 1'b0;
			done <= 1'b0;
			timedOut <= 1'b0;
			rdData <= 8'h00;
		end else if (clkEn) begin
			done <= 1'b0;
			unique case (state)
				SH_IDLE: begin
					if (start) begin
						op <= cmdOp;
						timedOut <= 1'b0;
						// Address width follows the capacity strap
						if (wideAddr) begin
							outBits <= {1'b1, cmdOp, cmdAddr, wrData};
							bitsLeft <= (cmdOp == spl_pkg::SPL_OP_READ ||
								cmdOp == spl_pkg::SPL_OP_WRITE) ? 5'h14 : 5'h0c;
						end else begin
							outBits <= {1'b1, cmdOp, cmdAddr[6:0], wrData, 2'h0};
							bitsLeft <= (cmdOp == spl_pkg::SPL_OP_READ ||
								cmdOp == spl_pkg::SPL_OP_WRITE) ? 5'h12 : 5'h0a;
						end
						memCs <= 1'b1;
						memSk <= 1'b0;
						memDi <= 1'b1;
						state <= SH_SHIFT;
					end
				end
				SH_SHIFT: begin
					if (tick) begin
						memSk <= ~memSk;
						if (memSk) begin
							// Read data is stable after the rising edge
							if (op == spl_pkg::SPL_OP_READ && bitsLeft <= 5'h08) begin
								rdData <= {rdData[6:0], memDataIn};
							end
							if (bitsLeft == 5'h01) begin
								memCs <= 1'b0;
								memDi <= 1'b0;
								state <= (op == spl_pkg::SPL_OP_WRITE ||
									op == spl_pkg::SPL_OP_ERASE) ? SH_GAP : SH_FIN;
							end else begin
								outBits <= {outBits[18:0], 1'b0};
								memDi <= outBits[18];
								bitsLeft <= bitsLeft - 5'h01;
							end
						end
					end
				end
				SH_GAP: begin
					if (tick) begin
						memCs <= 1'b1;
						waitCnt <= 24'h000000;
						state <= SH_POLL;
					end
				end
				SH_POLL: begin
					// Memory raises its data line once the program cycle ends;
					// first two synced samples still show the released line
					if (waitCnt >= 24'h000002 && memDataIn) begin
						memCs <= 1'b0;
						state <= SH_FIN;
					end else if (waitCnt == WR_TIMEOUT_CYC) begin
						memCs <= 1'b0;
						timedOut <= 1'b1;
						state <= SH_FIN;
					end else begin
						waitCnt <= waitCnt + 24'h000001;
					end
				end
				SH_FIN: begin
					done <= 1'b1;
					state <= SH_IDLE;
				end
			endcase
		end
	end

endmodule

// ---- test/spl_prom_loader_chk.sv ----
// Assertions on the loader's top-level ports
`timescale 1ns/1ps
module spl_prom_loader_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Memory pins
	input wire logic promCs,
	input wire logic promSk,
	input wire logic prom_capacity_strap,
	// Status
	input wire logic usbAccept,
	input wire logic loadDone,
	input wire logic promValid,
	input wire logic stationAddrLoad,
	input wire logic [9:0] devDescByteAddr,
	input wire logic [7:0] str0Len,
	input wire logic [7:0] str1Len,
	input wire logic [7:0] str2Len,
	input wire logic langIdEn,
	// Host
	input wire logic hostReq,
	input wire logic hostReady,
	input wire logic hostDone
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Serial clock rises counted per frame
	logic [4:0] skCnt;
	logic skPrev;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			skCnt <= 5'h00;
			skPrev <= 1'b0;
		end else begin
			skPrev <= promSk;
			if (!promCs) begin
				skCnt <= 5'h00;
			end else if (promSk && !skPrev) begin
				skCnt <= skCnt + 5'h01;
			end
		end
	end
	sequence skHigh;
		promSk [*8];
	endsequence
	sequence hostTaken;
		hostReady && hostReq;
	endsequence
	a_usb_held_off: assert property (!loadDone |-> !usbAccept)
		else $error("usb accepted before load");
	a_load_sticky: assert property (loadDone |=> loadDone)
		else $error("load status dropped");
	a_valid_after_load: assert property (promValid |-> loadDone)
		else $error("valid before load resolved");
	a_lang_from_len: assert property (loadDone |-> langIdEn ==
		(str0Len != 8'h00 || str1Len != 8'h00 || str2Len != 8'h00))
		else $error("language id not tied to lengths");
	a_word_offset: assert property (!devDescByteAddr[0])
		else $error("odd descriptor byte address");
	a_addr_pulse: assert property (stationAddrLoad |-> usbAccept
		##1 !stationAddrLoad)
		else $error("station load pulse wrong");
	a_host_after_load: assert property (hostReady |-> usbAccept)
		else $error("host access before load");
	a_host_take: assert property (hostTaken |=> !hostReady)
		else $error("ready held after take");
	a_done_pulse: assert property (hostDone |=> !hostDone)
		else $error("done longer than one cycle");
	a_sk_half: assert property ($rose(promSk) |-> skHigh)
		else $error("serial clock high too short");
	a_sk_in_frame: assert property (promSk |-> promCs)
		else $error("serial clock outside frame");
	a_addr_bits: assert property ($fell(promCs) |-> (skCnt == 5'h00 ||
		skCnt == (prom_capacity_strap ? 5'h0c : 5'h0a) ||
		skCnt == (prom_capacity_strap ? 5'h14 : 5'h12)))
		else $error("address bit count wrong");
endmodule
bind spl_prom_loader spl_prom_loader_chk chk_u (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .promCs(promCs), .promSk(promSk),
	.prom_capacity_strap(prom_capacity_strap),
	.usbAccept(usbAccept), .loadDone(loadDone), .promValid(promValid),
	.stationAddrLoad(stationAddrLoad), .devDescByteAddr(devDescByteAddr),
	.str0Len(str0Len), .str1Len(str1Len), .str2Len(str2Len),
	.langIdEn(langIdEn), .hostReq(hostReq), .hostReady(hostReady),
	.hostDone(hostDone));

// ---- test/spl_prom_model.sv ----
// Behavioural three-wire serial configuration memory
`timescale 1ns/1ps
module spl_prom_model #(
	parameter int BUSY_NS = 800
) (
	// Pins
	input wire logic cs,
	input wire logic sk,
	input wire logic di,
	input wire logic wide,
	output logic dout
);
	logic [7:0] mem [512];
	logic [31:0] sr;
	logic [1:0] op;
	logic [8:0] a;
	logic ewen, busy, polling;
	int n, ab;
	// Byte organised, 7 or 9 address bits
	assign ab = wide ? 9 : 7;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		{dout, ewen, busy, polling, n} = '0;
	end
	always @(posedge cs) begin
		n = 0;
		if (polling) dout = ~busy;
	end
	always @(busy) if (cs && polling) dout = ~busy;
	always @(posedge sk) if (cs && !polling) begin
		sr = {sr[30:0], di};
		n++;
		if (n == 3) op = sr[1:0];
		if (n == 3 + ab) a = 9'(sr) & (wide ? 9'h1ff : 9'h07f);
	end
	// Data leaves on the falling clock, MSB first
	always @(negedge sk) if (cs && op == 2'h2 && n >= 3 + ab && n < 11 + ab)
		dout = mem[a][10 + ab - n];
	// Released line shows no stale value
	always @(negedge cs) begin
		dout = ~dout;
		if (polling)
			polling = 0;
		else if (op == 2'h0 && n == 3 + ab)
			ewen = ((a >> (ab - 2)) == 9'h003);
		else if (ewen && ((op == 2'h1 && n == 11 + ab) ||
			(op == 2'h3 && n == 3 + ab))) begin
			mem[a] = op == 2'h1 ? sr[7:0] : 8'hff;
			polling = 1;
			busy = 1;
			busy <= #(BUSY_NS) 1'b0;
		end
	end
endmodule

// ---- test/spl_prom_loader_tb_top.sv ----
// Self-checking bench for the configuration memory loader
`timescale 1ns/1ps
module spl_prom_loader_tb_top;
	logic sys_clk, sys_rst, strap, hostReq, hostReady, hostDone, hostFail;
	logic promCs, promSk, promDi, promDataIn, usbAccept, loadDone, promValid;
	logic stationAddrLoad, devDescPresent, cfgDescPresent, langIdEn;
	logic [15:0] upper;
	logic [31:0] lower;
	logic [9:0] devAddr, cfgAddr;
	logic [7:0] s0, s1, s2, hostWrData, hostRdData;
	logic [8:0] hostAddr;
	spl_pkg::spl_host_op_t hostOp;
	int errors, compares;
	// Dev len 18, cfg and strings absent, so indexes are 00h
	logic [7:0] img [14] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
		8'h66, 8'h12, 8'h20, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
	always #2 sys_clk = ~sys_clk;
	spl_prom_loader #(.WR_TIMEOUT_CYC(24'h0000c8)) dut_u (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .clkEn(1'b1), .prom_capacity_strap(strap),
		.promDataIn(promDataIn), .promCs(promCs), .promSk(promSk),
		.promDi(promDi), .usbAccept(usbAccept), .loadDone(loadDone),
		.promValid(promValid), .station_addr_upper_reg(upper),
		.station_addr_lower_reg(lower), .stationAddrLoad(stationAddrLoad),
		.devDescPresent(devDescPresent), .devDescByteAddr(devAddr),
		.cfgDescPresent(cfgDescPresent), .cfgDescByteAddr(cfgAddr),
		.str0Len(s0), .str1Len(s1), .str2Len(s2), .langIdEn(langIdEn),
		.hostReq(hostReq), .hostOp(hostOp), .hostAddr(hostAddr),
		.hostWrData(hostWrData), .hostReady(hostReady), .hostDone(hostDone),
		.hostFail(hostFail), .hostRdData(hostRdData));
	spl_prom_model mdl_u (.cs(promCs), .sk(promSk), .di(promDi),
		.wide(strap), .dout(promDataIn));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic boot(logic w);
		int i;
		@(posedge sys_clk);
		strap <= w;
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		chk("usbAccept", 0, usbAccept);
		for (i = 0; i < 80000 && loadDone !== 1'b1; i++) @(negedge sys_clk);
		chk("loadDone", 1, loadDone);
	endtask
	task automatic host(spl_pkg::spl_host_op_t op, logic [8:0] a, logic [7:0] d);
		int i;
		for (i = 0; i < 100 && hostReady !== 1'b1; i++) @(negedge sys_clk);
		@(posedge sys_clk);
		hostReq <= 1'b1;
		hostOp <= op;
		hostAddr <= a;
		hostWrData <= d;
		@(posedge sys_clk);
		hostReq <= 1'b0;
		for (i = 0; i < 20000 && hostDone !== 1'b1; i++) @(negedge sys_clk);
		chk("hostDone", 1, hostDone);
		chk("hostFail", 0, hostFail);
	endtask
	task automatic t_bad_sig;
		foreach (img[i]) mdl_u.mem[i] = img[i];
		boot(1'b1);
		chk("promValid", 0, promValid);
		chk("usbAccept", 1, usbAccept);
		chk("upper", 0, upper);
		chk("lower", 0, lower);
		chk("addrLoad", 0, stationAddrLoad);
		chk("devPresent", 0, devDescPresent);
		$display("t_bad_sig done");
	endtask
	// High address needs all nine bits
	task automatic t_host;
		host(spl_pkg::SPL_HOST_WRITE, 9'h1f3, 8'h3c);
		chk("mem write", 8'h3c, mdl_u.mem[9'h1f3]);
		// Done only once the program cycle is over
		chk("write busy", 0, mdl_u.busy);
		host(spl_pkg::SPL_HOST_READ, 9'h1f3, 8'h00);
		chk("hostRdData", 8'h3c, hostRdData);
		host(spl_pkg::SPL_HOST_ERASE, 9'h1f3, 8'h00);
		chk("mem erase", 8'hff, mdl_u.mem[9'h1f3]);
		chk("erase busy", 0, mdl_u.busy);
		$display("t_host done");
	endtask
	task automatic t_good_load;
		mdl_u.mem[0] = 8'ha5;
		boot(1'b0);
		chk("promValid", 1, promValid);
		chk("upper", 16'h6655, upper);
		chk("lower", 32'h44332211, lower);
		chk("devPresent", 1, devDescPresent);
		chk("devAddr", 10'h040, devAddr);
		chk("cfgPresent", 0, cfgDescPresent);
		chk("cfgAddr", 10'h060, cfgAddr);
		chk("str0Len", 0, s0);
		chk("str1Len", 0, s1);
		chk("str2Len", 0, s2);
		chk("addrLoad", 1, stationAddrLoad);
		chk("langIdEn", 0, langIdEn);
		chk("hostReady", 1, hostReady);
		$display("t_good_load done");
	endtask
	task automatic final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		strap = 1'b0;
		hostReq = 1'b0;
		hostOp = spl_pkg::SPL_HOST_READ;
		hostAddr = 9'h000;
		hostWrData = 8'h00;
		errors = 0;
		compares = 0;
		#1;
		t_bad_sig;
		t_host;
		t_good_load;
		final_report;
	end
	// Clean run takes about 88000 cycles
	initial begin
		#(95000 * 4);
		errors++;
		final_report;
	end
endmodule
